//--- logic/agpoc_ctrl.sv
module agpoc_ctrl
  import agpoc_pkg::*;
#(
  parameter int SLOW_WAKE = SLOW_WAKE_CYC,
  parameter int REF_SETTLE = REF_SETTLE_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_clk,
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic pdn_pin,
  input wire logic serial_in_pin,
  input wire logic mode_select_pin,
  output logic ref_ext_en,
  output logic vcm_drive_en,
  output logic coarse_gain_en,
  output logic [2:0] fine_gain,
  output logic [11:0] fs_range_mv,
  output logic core_pd,
  output logic ref_pd,
  output logic clk_stopped,
  output logic data_valid,
  output logic [DATA_W-1:0] cmos_data,
  output logic cmos_data_oe,
  output logic [LVDS_PAIRS-1:0] lvds_data,
  output logic lvds_data_oe,
  output logic forwarded_clock,
  output logic forwarded_clock_oe
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [DATA_W+3:0] pin_s;
  logic sclk_s;
  logic pdn_s;
  logic obuf_pin_s;
  logic msel_s;
  logic [DATA_W-1:0] serial_in_pin_s;
  logic sclk_d_r;
  logic s_rise;
  logic s_fall;

  agpoc_sync #(.W(DATA_W+4)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d({sample_clk, pdn_pin, serial_in_pin, mode_select_pin, sample_data}),
    .q(pin_s)
  );

  assign {sclk_s, pdn_s, obuf_pin_s, msel_s, serial_in_pin_s} = pin_s;
  assign s_rise = sclk_s & ~sclk_d_r;
  assign s_fall = ~sclk_s & sclk_d_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sclk_d_r <= 1'b0;
    else
      sclk_d_r <= sclk_s;
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  agpoc_cfg_t cfg_r;
  agpoc_pwr_t mode_r;
  logic ref_settled_r;
  logic lvds_sel;
  logic setup;
  logic wr_en;
  logic [31:0] rd_nxt;
  logic rd_err;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign lvds_sel = cfg_r.use_serial ? cfg_r.lvds : msel_s;

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == OFF_CTRL)
      rd_nxt = 32'(cfg_r);
    else if (paddr == OFF_STATUS)
      rd_nxt = {26'h0, lvds_sel, ref_settled_r, data_valid, clk_stopped, mode_r};
    else if (paddr == OFF_RANGE)
      rd_nxt = {17'h0, fine_gain, 12'(fs_range_mv)};
    else
      rd_err = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      // one wait-free access phase per setup
      pready <= setup;
      pslverr <= setup & rd_err;
      if (setup)
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_r <= agpoc_cfg_t'(CTRL_RST[10:0]);
    else if (wr_en && paddr == OFF_CTRL)
      cfg_r <= agpoc_cfg_t'(pwdata[B_USE_SERIAL:B_REF_EXT]);
  end

  // ----------------------------------------
  // reference and gain
  // ----------------------------------------
  logic [2:0] fine_eff;

  // fine gain clipped to 6 dB
  assign fine_eff = (cfg_r.fine > FINE_MAX_DB) ? FINE_MAX_DB : cfg_r.fine;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_ext_en <= 1'b0;
      vcm_drive_en <= 1'b1;
      coarse_gain_en <= 1'b0;
      fine_gain <= 3'h0;
      fs_range_mv <= FS_0DB_MV;
    end
    else
    begin
      // pin is input in external mode
      ref_ext_en <= cfg_r.ref_ext;
      vcm_drive_en <= ~cfg_r.ref_ext;
      coarse_gain_en <= cfg_r.coarse;
      fine_gain <= cfg_r.coarse ? 3'h0 : fine_eff;
      if (cfg_r.coarse)
        fs_range_mv <= FS_COARSE_MV;
      else
        case (fine_eff)
          3'h1: fs_range_mv <= FS_FINE1_MV;
          3'h2: fs_range_mv <= FS_FINE2_MV;
          3'h3: fs_range_mv <= FS_FINE3_MV;
          3'h4: fs_range_mv <= FS_FINE4_MV;
          3'h5: fs_range_mv <= FS_FINE5_MV;
          3'h6: fs_range_mv <= FS_FINE6_MV;
          default: fs_range_mv <= FS_0DB_MV;
        endcase
    end
  end

  // ----------------------------------------
  // power modes
  // ----------------------------------------
  logic pd_req;
  logic ob_req;
  agpoc_pwr_t mode_nxt;
  logic [16:0] wake_cnt_r;
  logic [16:0] ref_cnt_r;
  logic [7:0] stop_cnt_r;

  assign pd_req = cfg_r.use_serial ? cfg_r.stby : pdn_s;
  assign ob_req = cfg_r.use_serial ? cfg_r.pdn_obuf : obuf_pin_s;

  always_comb
  begin
    case ({ob_req, pd_req})
      2'b01: mode_nxt = PWR_STANDBY;
      2'b10: mode_nxt = PWR_OBUF_OFF;
      2'b11: mode_nxt = PWR_GLOBAL;
      default: mode_nxt = PWR_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_r <= PWR_NORMAL;
      core_pd <= 1'b0;
      ref_pd <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      // global powers down core and refs
      core_pd <= (mode_nxt == PWR_STANDBY) || (mode_nxt == PWR_GLOBAL);
      ref_pd <= (mode_nxt == PWR_GLOBAL);
    end
  end

  // no rising edge for 1 us means stopped
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stop_cnt_r <= 8'h00;
      clk_stopped <= 1'b0;
    end
    else if (s_rise)
    begin
      stop_cnt_r <= 8'h00;
      clk_stopped <= 1'b0;
    end
    else if (stop_cnt_r == 8'(CLK_STOP_CYC - 1))
      clk_stopped <= 1'b1;
    else
      stop_cnt_r <= stop_cnt_r + 8'h01;
  end

  // wake counter reloads while asleep, so it runs from the exit
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      wake_cnt_r <= 17'h0_0000;
    else if (clk_stopped || mode_r == PWR_STANDBY || mode_r == PWR_GLOBAL)
      wake_cnt_r <= 17'(SLOW_WAKE);
    else if (mode_r == PWR_OBUF_OFF)
      wake_cnt_r <= lvds_sel ? 17'(OBUF_LVDS_CYC) : 17'(OBUF_CMOS_CYC);
    else if (wake_cnt_r != 17'h0_0000)
      wake_cnt_r <= wake_cnt_r - 17'h0_0001;
  end

  // references settle 1 ms after global exit
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_cnt_r <= 17'h0_0000;
      ref_settled_r <= 1'b1;
    end
    else
    begin
      if (mode_r == PWR_GLOBAL)
        ref_cnt_r <= 17'(REF_SETTLE);
      else if (ref_cnt_r != 17'h0_0000)
        ref_cnt_r <= ref_cnt_r - 17'h0_0001;
      ref_settled_r <= (ref_cnt_r == 17'h0_0000) && (mode_r != PWR_GLOBAL);
    end
  end

  logic stop_hit;

  // look ahead so valid drops in the same cycle as the stop flag
  assign stop_hit = (stop_cnt_r == 8'(CLK_STOP_CYC - 1)) && !s_rise;

  // next mode, not current, so valid never overlaps a power-down
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      data_valid <= 1'b0;
    else
      data_valid <= (mode_nxt == PWR_NORMAL) && !clk_stopped && !stop_hit && (wake_cnt_r == 17'h0_0000);
  end

  // ----------------------------------------
  // sample pipeline and buffer
  // ----------------------------------------
  localparam int STAGES = PIPE_LATENCY - 1;

  logic [DATA_W-1:0] pipe_r [STAGES];
  logic [STAGES-1:0] pvld_r;
  logic flush;
  logic shift;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic [DATA_W-1:0] pop_data;

  // stale samples are dropped on any sleep
  assign flush = (mode_r != PWR_NORMAL) | clk_stopped;
  assign push_valid = s_rise & pvld_r[STAGES-1];
  // a full buffer stalls the pipeline
  assign shift = s_rise & (push_ready | ~pvld_r[STAGES-1]);
  assign pop_ready = s_rise & data_valid;

  // eight stages plus buffer pop make nine
  always_ff @(posedge sys_clk)
  begin
    if (shift)
    begin
      pipe_r[0] <= serial_in_pin_s;
      for (int i = 1; i < STAGES; i++)
        pipe_r[i] <= pipe_r[i-1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pvld_r <= '0;
    else if (flush)
      pvld_r <= '0;
    else if (shift)
      pvld_r <= {pvld_r[STAGES-2:0], 1'b1};
  end

  agpoc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .flush(flush),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(pipe_r[STAGES-1]),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // ----------------------------------------
  // output interface
  // ----------------------------------------
  logic [DATA_W-1:0] word_r;
  logic [DATA_W-1:0] word_nxt;
  logic obuf_off;

  // two's complement flips the sign bit
  assign word_nxt = cfg_r.twos ? {~pop_data[DATA_W-1], pop_data[DATA_W-2:0]} : pop_data;
  assign obuf_off = (mode_nxt == PWR_OBUF_OFF) || (mode_nxt == PWR_GLOBAL);

  function automatic logic [LVDS_PAIRS-1:0] pick(input logic [DATA_W-1:0] w, input logic odd);
    logic [2*LVDS_PAIRS-1:0] ext;
    logic [LVDS_PAIRS-1:0] r;
    ext = {{(2*LVDS_PAIRS-DATA_W){1'b0}}, w};
    r = '0;
    for (int i = 0; i < LVDS_PAIRS; i++)
      r[i] = ext[2*i + int'(odd)];
    return r;
  endfunction

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_r <= '0;
      cmos_data <= '0;
      lvds_data <= '0;
    end
    else
    begin
      if (pop_valid && pop_ready)
      begin
        word_r <= word_nxt;
        // even bits with the rising edge
        lvds_data <= pick(word_nxt, 1'b0);
      end
      else if (s_fall && data_valid)
        // odd bits with the falling edge
        lvds_data <= pick(word_r, 1'b1);
      // all bits once per sample, mid-period
      // data settles before the clock rises
      if (s_fall && data_valid)
        cmos_data <= word_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      forwarded_clock <= 1'b0;
      forwarded_clock_oe <= 1'b0;
      cmos_data_oe <= 1'b0;
      lvds_data_oe <= 1'b0;
    end
    else
    begin
      // shifted clock lags by one sys cycle
      forwarded_clock <= cfg_r.clk_shift ? sclk_d_r : sclk_s;
      forwarded_clock_oe <= ~obuf_off;
      // one interface active at a time
      cmos_data_oe <= ~obuf_off & ~lvds_sel;
      lvds_data_oe <= ~obuf_off & lvds_sel;
    end
  end

endmodule // agpoc_ctrl

//--- logic/agpoc_fifo.sv
module agpoc_fifo
#(
  parameter int W = 12,
  parameter int DEPTH = 4
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_r[wr_r] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else if (flush)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      if (pop)
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // agpoc_fifo

//--- logic/agpoc_pkg.sv
package agpoc_pkg;

  // ----------------------------------------
  // clock and sizes
  // ----------------------------------------
  localparam int SYS_MHZ = 100;
  localparam int DATA_W = 12;
  localparam int LVDS_PAIRS = 7;
  localparam int PIPE_LATENCY = 9;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RANGE = 8'h08;

  // ----------------------------------------
  // control field positions and reset value
  // ----------------------------------------
  localparam int B_REF_EXT = 0;
  localparam int B_COARSE = 1;
  localparam int B_FINE_LO = 2;
  localparam int B_PDN_OBUF = 5;
  localparam int B_STBY = 6;
  localparam int B_LVDS = 7;
  localparam int B_TWOS = 8;
  localparam int B_CLK_SHIFT = 9;
  localparam int B_USE_SERIAL = 10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ----------------------------------------
  // gain and full-scale range
  // ----------------------------------------
  localparam logic [2:0] FINE_MAX_DB = 3'h6;
  localparam int REF_GAIN_CENTI = 133;
  localparam logic [11:0] FS_0DB_MV = 12'd2000;
  localparam logic [11:0] FS_COARSE_MV = 12'd1340;
  localparam logic [11:0] FS_FINE1_MV = 12'd1780;
  localparam logic [11:0] FS_FINE2_MV = 12'd1590;
  localparam logic [11:0] FS_FINE3_MV = 12'd1420;
  localparam logic [11:0] FS_FINE4_MV = 12'd1260;
  localparam logic [11:0] FS_FINE5_MV = 12'd1120;
  localparam logic [11:0] FS_FINE6_MV = 12'd1000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int T_SLOW_WAKE_US = 50;
  localparam int T_REF_SETTLE_MS = 1;
  localparam int T_OBUF_LVDS_NS = 500;
  localparam int T_OBUF_CMOS_NS = 200;
  localparam int T_CLK_STOP_NS = 1000;
  localparam int SLOW_WAKE_CYC = T_SLOW_WAKE_US * SYS_MHZ;
  localparam int REF_SETTLE_CYC = T_REF_SETTLE_MS * 1000 * SYS_MHZ;
  localparam int OBUF_LVDS_CYC = (T_OBUF_LVDS_NS * SYS_MHZ) / 1000;
  localparam int OBUF_CMOS_CYC = (T_OBUF_CMOS_NS * SYS_MHZ) / 1000;
  localparam int CLK_STOP_CYC = (T_CLK_STOP_NS * SYS_MHZ + 999) / 1000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {PWR_NORMAL, PWR_STANDBY, PWR_OBUF_OFF, PWR_GLOBAL} agpoc_pwr_t;

  typedef struct packed {
    logic use_serial;
    logic clk_shift;
    logic twos;
    logic lvds;
    logic stby;
    logic pdn_obuf;
    logic [2:0] fine;
    logic coarse;
    logic ref_ext;
  } agpoc_cfg_t;

endpackage

//--- logic/agpoc_sync.sv
module agpoc_sync
#(
  parameter int W = 1
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // agpoc_sync

//--- sim/agpoc_asserts.sv
module agpoc_asserts
  import agpoc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ref_ext_en,
  input wire logic vcm_drive_en,
  input wire logic coarse_gain_en,
  input wire logic [2:0] fine_gain,
  input wire logic [11:0] fs_range_mv,
  input wire logic core_pd,
  input wire logic ref_pd,
  input wire logic clk_stopped,
  input wire logic data_valid,
  input wire logic [DATA_W-1:0] cmos_data,
  input wire logic cmos_data_oe,
  input wire logic lvds_data_oe,
  input wire logic forwarded_clock_oe
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_ref_pin_dir: assert property (vcm_drive_en == !ref_ext_en)
    else $error("common-mode drive and external reference overlap");
  a_fine_in_range: assert property (fine_gain <= FINE_MAX_DB && !(coarse_gain_en && fine_gain != 3'h0))
    else $error("fine gain outside its range");
  a_range_coarse: assert property (coarse_gain_en && $stable(coarse_gain_en) |-> fs_range_mv == FS_COARSE_MV)
    else $error("coarse range wrong");
  a_reset_zero_gain: assert property ($rose(rst_b) |-> !coarse_gain_en && fine_gain == 3'h0 && fs_range_mv == FS_0DB_MV)
    else $error("gain not zero after reset");
  a_global_all_off: assert property (ref_pd |-> core_pd && !cmos_data_oe && !lvds_data_oe && !forwarded_clock_oe)
    else $error("global power down leaves something on");
  a_core_off_no_data: assert property (core_pd |-> !data_valid)
    else $error("data valid with core down");
  a_wake_not_early: assert property ($fell(core_pd) |-> !data_valid [*8])
    else $error("data valid too soon after wake");
  a_stop_no_data: assert property (clk_stopped |-> !data_valid)
    else $error("data valid while clock stopped");
  a_one_interface: assert property (!(cmos_data_oe && lvds_data_oe))
    else $error("both interfaces enabled");
  a_cmos_word_holds: assert property ($changed(cmos_data) |=> ($stable(cmos_data) || !data_valid) [*8])
    else $error("cmos word changed within a sample period");
endmodule // agpoc_asserts

bind agpoc_ctrl agpoc_asserts chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .ref_ext_en(ref_ext_en),
  .vcm_drive_en(vcm_drive_en), .coarse_gain_en(coarse_gain_en), .fine_gain(fine_gain),
  .fs_range_mv(fs_range_mv), .core_pd(core_pd), .ref_pd(ref_pd), .clk_stopped(clk_stopped),
  .data_valid(data_valid), .cmos_data(cmos_data), .cmos_data_oe(cmos_data_oe),
  .lvds_data_oe(lvds_data_oe), .forwarded_clock_oe(forwarded_clock_oe));

//--- sim/agpoc_rx.sv
module agpoc_rx
  import agpoc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic forwarded_clock,
  input wire logic [DATA_W-1:0] cmos_data,
  input wire logic [LVDS_PAIRS-1:0] lvds_data,
  output logic [DATA_W-1:0] cmos_word,
  output logic cmos_stb,
  output logic [DATA_W-1:0] lvds_word,
  output logic lvds_stb
);
  timeunit 1ns;
  timeprecision 100ps;
  logic fc_r;
  logic [LVDS_PAIRS-1:0] even_r;
  // sampled one cycle after the edge so data has settled
  always_ff @(posedge sys_clk)
  begin
    fc_r <= forwarded_clock;
    cmos_stb <= forwarded_clock && !fc_r;
    lvds_stb <= !forwarded_clock && fc_r;
    if (forwarded_clock && !fc_r)
    begin
      cmos_word <= cmos_data;
      even_r <= lvds_data;
    end
    if (!forwarded_clock && fc_r)
      for (int i = 0; i < 6; i++)
      begin
        lvds_word[2*i] <= even_r[i];
        lvds_word[2*i+1] <= lvds_data[i];
      end
  end
endmodule // agpoc_rx

//--- sim/test_adc_gain_power_output_ctrl.sv
module test_adc_gain_power_output_ctrl
  import agpoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic sample_clk = 0, run_clk = 1, pdn_pin = 0, serial_in_pin = 0, mode_select_pin = 0;
  logic mon_on = 0, twos_exp = 0, sc_r = 0, ref_ext_en, vcm_drive_en, coarse_gain_en, core_pd, ref_pd;
  logic clk_stopped, data_valid, cmos_data_oe, lvds_data_oe, forwarded_clock, forwarded_clock_oe, cmos_stb, lvds_stb;
  logic [2:0] fine_gain;
  logic [11:0] fs_range_mv, sample_data = 12'h000, cmos_data, cmos_word, lvds_word;
  logic [6:0] lvds_data;
  int fail_count = 0, checks = 0, rise_cnt = 0, lag = 0, last_lag, lag0, t, c0;
  // ctrl value, expected range readback
  logic [31:0] rows [9][2] = '{'{32'h000, 32'h07D0}, '{32'h004, 32'h16F4}, '{32'h008, 32'h2636},
    '{32'h00C, 32'h358C}, '{32'h010, 32'h44EC}, '{32'h014, 32'h5460}, '{32'h018, 32'h63E8},
    '{32'h01C, 32'h63E8}, '{32'h00F, 32'h053C}};

  agpoc_ctrl #(.SLOW_WAKE(50), .REF_SETTLE(200)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_clk(sample_clk), .sample_data(sample_data), .pdn_pin(pdn_pin),
    .serial_in_pin(serial_in_pin), .mode_select_pin(mode_select_pin), .ref_ext_en(ref_ext_en),
    .vcm_drive_en(vcm_drive_en), .coarse_gain_en(coarse_gain_en), .fine_gain(fine_gain),
    .fs_range_mv(fs_range_mv), .core_pd(core_pd), .ref_pd(ref_pd), .clk_stopped(clk_stopped),
    .data_valid(data_valid), .cmos_data(cmos_data), .cmos_data_oe(cmos_data_oe), .lvds_data(lvds_data),
    .lvds_data_oe(lvds_data_oe), .forwarded_clock(forwarded_clock), .forwarded_clock_oe(forwarded_clock_oe));
  agpoc_rx rx_u (.sys_clk(sys_clk), .forwarded_clock(forwarded_clock), .cmos_data(cmos_data),
    .lvds_data(lvds_data), .cmos_word(cmos_word), .cmos_stb(cmos_stb), .lvds_word(lvds_word), .lvds_stb(lvds_stb));

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // sample clock stands still while stopped
  initial
  begin
    #3.3;
    forever #62.5 if (run_clk) sample_clk = ~sample_clk;
  end
  function automatic logic [11:0] word(input int n);
    return 12'(n * 12'h0D5) ^ {twos_exp, 11'h000};
  endfunction
  always @(posedge sys_clk)
  begin
    sc_r <= sample_clk;
    lag <= (!sc_r && sample_clk) ? 0 : lag + 1;
    if (sc_r && !sample_clk) sample_data <= sample_data + 12'h0D5;
    if (!sc_r && sample_clk) rise_cnt <= rise_cnt + 1;
    if (cmos_stb === 1'b1) last_lag <= lag;
    if (mon_on && cmos_stb === 1'b1 && cmos_data_oe === 1'b1) cmp("cmos", word(rise_cnt - 11), cmos_word);
    if (mon_on && lvds_stb === 1'b1 && lvds_data_oe === 1'b1) cmp("lvds", word(rise_cnt - 10), lvds_word);
    if (mon_on && !sc_r && sample_clk && cmos_data_oe === 1'b1) cmp("ext_clk", word(rise_cnt - 10), cmos_data);
  end

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_valid();
    t = 0;
    while (data_valid !== 1'b1 && t < 900)
    begin
      @(posedge sys_clk);
      t++;
    end
  endtask
  task automatic stream(input logic lv);
    mon_on <= 0;
    mode_select_pin <= lv;
    repeat (20) @(posedge sys_clk);
    wait_valid();
    repeat (200) @(posedge sys_clk);
    c0 = checks;
    mon_on <= 1;
    repeat (130) @(posedge sys_clk);
    mon_on <= 0;
    cmp("words", 1, checks > c0 + 5);
    cmp("oe", {lv, !lv}, {lvds_data_oe, cmos_data_oe});
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1;
    foreach (rows[i])
    begin
      apb(1, OFF_CTRL, rows[i][0]);
      apb(0, OFF_RANGE, 32'h0);
      cmp("range", rows[i][1], rd);
      cmp("pins", {rows[i][0][0], rows[i][1][11:0]}, {ref_ext_en, fs_range_mv});
    end
    apb(1, OFF_CTRL, 32'h0);
    wait_valid();
    for (int i = 0; i < 8; i++)
    begin
      pdn_pin <= !i[2] && i[0];
      serial_in_pin <= !i[2] && i[1];
      apb(1, OFF_CTRL, {i[2], 3'h0, i[0], i[1], 5'h00});
      repeat (5) @(posedge sys_clk);
      apb(0, OFF_STATUS, 32'h0);
      cmp("mode", i[1:0], rd[1:0]);
      cmp("power", {i[0], i[0] && i[1], !i[1]}, {core_pd, ref_pd, cmos_data_oe});
      pdn_pin <= 0;
      serial_in_pin <= 0;
      apb(1, OFF_CTRL, 32'h0);
      wait_valid();
      cmp("wake", 1, i[0] ? (t >= 45 && t <= 60) : i[1] ? (t >= 15 && t <= 30) : t <= 3);
    end
    stream(0);
    apb(1, OFF_CTRL, 32'h100);
    twos_exp <= 1;
    stream(0);
    stream(1);
    repeat (30) @(posedge sys_clk);
    lag0 = last_lag;
    apb(1, OFF_CTRL, 32'h300);
    repeat (30) @(posedge sys_clk);
    cmp("shift", lag0 + 1, last_lag);
    run_clk <= 0;
    repeat (150) @(posedge sys_clk);
    cmp("stop", 2'b10, {clk_stopped, data_valid});
    run_clk <= 1;
    wait_valid();
    cmp("restart", 1, t >= 45 && t <= 80);
    apb(0, 8'h0C, 32'h0);
    cmp("unmapped_err", 1, er);
    cmp("unmapped_data", 0, rd);
    rst_b <= 0;
    repeat (2) @(posedge sys_clk);
    cmp("in_reset", {1'b1, FS_0DB_MV, 1'b0}, {vcm_drive_en, fs_range_mv, core_pd});
    rst_b <= 1;
    apb(0, OFF_CTRL, 32'h0);
    cmp("ctrl_rst", CTRL_RST, rd);
    apb(0, OFF_RANGE, 32'h0);
    cmp("range_rst", 32'h07D0, rd);
    wrap_up();
  end
endmodule // test_adc_gain_power_output_ctrl
